// [rtc_pkg.sv]
// rtc_pkg: shared constants for the serial clock/calendar link and its controller.
// assumes: both ends and the bench import this package.
package rtc_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 4;
  localparam int FRAME_BITS = 8;            // address nibble then filler nibble
  localparam int WR_EDGE = 8;               // direction sampled at this rising edge
  localparam logic [3:0] ADDR_CONTROL_ONE = 4'h_d;
  localparam logic [3:0] ADDR_INITIAL_MODE = 4'h_f;
  localparam logic [3:0] ADDR_CONTROL_TWO = 4'h_e;
  localparam logic [3:0] ADDR_SECONDS = 4'h_0;
  localparam logic [3:0] ADDR_MINUTES = 4'h_1;
  localparam logic [3:0] ADDR_HOURS = 4'h_2;
  localparam logic [3:0] ADDR_LAST_COUNTER = 4'h_2;
  localparam logic [3:0] CLOCK_MODE_VALUE = 4'h_0;
  localparam logic [3:0] CONTROL_ONE_INIT = 4'h_9;  // 1 hz output, 24-hour
  localparam logic [3:0] CONTROL_ONE_RESET = 4'h_0;
  localparam logic [3:0] INITIAL_MODE_RESET = 4'h_1; // ordinary mode after clear
  localparam int POWER_CLEAR_BIT = 2;
  localparam int SYSTEM_RESET_BIT = 0;
  localparam logic [3:0] CONTROL_TWO_RESET = 4'h_4;  // power-up-clear flag set
  localparam logic [3:0] COUNTER_MAX = 4'h_f;
  // controller register map
  localparam logic [3:0] REG_CMD = 4'h_0;     // w: [3:0] addr, [4] read, [5] go, [6] sysrst
  localparam logic [3:0] REG_WDATA = 4'h_1;   // w: data nibble for register writes
  localparam logic [3:0] REG_STATUS = 4'h_2;  // r: [0] busy, [7:4] last read data
  localparam int CMD_READ_BIT = 4;
  localparam int CMD_GO_BIT = 5;
  localparam int CMD_SYSRST_BIT = 6;
  localparam int CLK_DIV = 4;                 // link clock half period in clk cycles
  localparam logic [3:0] DIV_ONE = 4'h_1;
endpackage : rtc_pkg

// [rtc_link_if.sv]
// rtc_link_if: serial pins between controller and clock/calendar device.
// assumes: the controller makes the link clock; the device runs on it.
`timescale 1ns/1ps
interface rtc_link_if;
  logic cs_n;          // chip select, active low
  logic wr_n;          // low = write, high = read
  logic sck;           // serial clock from controller
  logic sin;           // serial data to device
  logic sout;          // serial data from device
  logic sout_oe;       // device drives sout
  logic backup_n;      // low = access inhibit
  modport device (input cs_n, input wr_n, input sck, input sin, input backup_n,
                  output sout, output sout_oe);
  modport host (output cs_n, output wr_n, output sck, output sin, input sout, input sout_oe);
endinterface : rtc_link_if

// [rtc_shift_unit.sv]
// rtc_shift_unit: bit counter and shift register for one link frame.
// assumes: clocked by the link clock; clear is asynchronous, as that clock stops between frames.
`timescale 1ns/1ps
module rtc_shift_unit
  import rtc_pkg::*;
#(
  parameter int WIDTH = 12
) (
  input wire logic clk,                  // link clock
  input wire logic clear,                // restart frame
  input wire logic bit_in,               // serial bit
  output logic [WIDTH-1:0] shift_word,   // msb-first collected bits
  output logic [4:0] edge_count          // rising edges seen
);
  // collect one bit per edge; count saturates well above a frame
  always_ff @(posedge clk or posedge clear) begin
    if (clear) begin
      shift_word <= '0;
      edge_count <= '0;
    end else begin
      shift_word <= {shift_word[WIDTH-2:0], bit_in};
      if (edge_count != 5'h_1f) edge_count <= edge_count + 5'h_1;
    end
  end
endmodule : rtc_shift_unit

// [rtc_device.sv]
// rtc_device: serial access logic of the clock/calendar device.
// assumes: sck from the controller is its clock; rst is power-on.
// Function
// - power-up clears all logic automatically
// - power-up-clear flag reads 1 after power-on
// - system reset bit reinitialises all logic; here control two only clears its system reset bit and keeps its other bits
// - host raises cs before dropping sck; the host here drops sck one clk before raising cs
// - address f data 0 selects clock mode
// - address d data 9 sets control one
// - cs low, wr high selects read
// - address taken from first four rising edges
// - read data shifted out on rising edges
// - cs low, wr low selects write
// - write samples address and data bits
// - register write loads four shifted bits
// - counter write increments counter
// - backup low inhibits serial access
`timescale 1ns/1ps
module rtc_device
  import rtc_pkg::*;
(
  input wire logic sck,            // link clock
  input wire logic srst,           // power-on reset, sync to sck
  rtc_link_if.device link,         // serial pins
  output logic [3:0] control_one,  // visible control one
  output logic clock_mode          // 1 = clock mode
);
  ////////////////////////////////////////////////////////////////////
  // edge numbers inside a frame, as edge_count stands just before that edge
  localparam logic [4:0] EDGE_ADDR_LAST = 5'(ADDR_W - 1); // fourth rise: address complete
  localparam logic [4:0] EDGE_DIRECTION = 5'(WR_EDGE - 1); // eighth rise: direction taken
  localparam logic [4:0] EDGE_DATA_LAST = 5'(WR_EDGE + DATA_W - 1); // twelfth rise: data in
  localparam logic [4:0] EDGE_VALUE_FIRST = 5'(WR_EDGE + ADDR_W - 1); // address echo done
  localparam logic [4:0] EDGE_READ_END = 5'(WR_EDGE + ADDR_W + DATA_W); // seventeenth rise: first one not driven
  localparam int SHIFT_W = 12; // history for address, filler and data

  // frame state, cleared whenever chip select is high
  logic [SHIFT_W-1:0] shift_word;
  logic [4:0] edge_count;
  logic [3:0] frame_addr;
  logic frame_read;
  logic [3:0] read_word;
  logic [3:0] addr_value;
  logic frame_clear;
  // device registers and counters
  logic [3:0] initial_mode_select;
  logic [3:0] control_register_two;
  logic [3:0] counters [0:ADDR_LAST_COUNTER];
  // reset sources and write strobes
  logic sys_reset;
  logic reset_all;
  logic inhibit;
  logic write_reg_now;
  logic write_cnt_now;

  ////////////////////////////////////////////////////////////////////
  // reset sources; the system reset bit clears itself one edge after it is set
  assign sys_reset = control_register_two[SYSTEM_RESET_BIT];
  assign reset_all = srst || sys_reset;
  // backup low shuts the serial port; the registers keep their contents
  assign inhibit = !link.backup_n;
  assign clock_mode = (initial_mode_select == CLOCK_MODE_VALUE);
  // sck stops while deselected, so cs high must clear the frame with no edge at all
  assign frame_clear = link.cs_n || reset_all || inhibit;

  ////////////////////////////////////////////////////////////////////
  // frame shifter; cs high restarts it so a cut frame leaves no trace
  rtc_shift_unit #(.WIDTH(SHIFT_W)) shifter (
    .clk(sck),
    .clear(frame_clear),
    .bit_in(link.sin),
    .shift_word(shift_word),
    .edge_count(edge_count)
  );

  // address is the first four bits; the filler nibble is ignored
  always_ff @(posedge sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      frame_addr <= '0;
    end else if (reset_all) begin
      frame_addr <= '0;
    end else if (edge_count == EDGE_ADDR_LAST) begin
      frame_addr <= {shift_word[2:0], link.sin};
    end
  end

  // direction taken at the eighth rising edge, held to the end of the frame
  always_ff @(posedge sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      frame_read <= 1'b0;
    end else if (reset_all) begin
      frame_read <= 1'b0;
    end else if (edge_count == EDGE_DIRECTION) begin
      frame_read <= link.wr_n;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // register file as a read sees it; unmapped addresses read as zero
  function automatic logic [3:0] reg_value(input logic [3:0] a);
    logic [3:0] v;
    v = '0;
    if (a == ADDR_CONTROL_ONE) v = control_one;
    else if (a == ADDR_INITIAL_MODE) v = initial_mode_select;
    else if (a == ADDR_CONTROL_TWO) v = control_register_two;
    else if (a <= ADDR_LAST_COUNTER) v = counters[a[1:0]];
    return v;
  endfunction : reg_value

  // always_comb also follows the registers that the function reads
  always_comb begin
    addr_value = reg_value(frame_addr);
  end

  ////////////////////////////////////////////////////////////////////
  // read path: address echo then data, msb first, changing on rising edges;
  // cs high releases the pin at once, since no further sck edge will come
  always_ff @(posedge sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      read_word <= '0;
      link.sout <= 1'b0;
      link.sout_oe <= 1'b0;
    end else if (reset_all || inhibit) begin
      read_word <= '0;
      link.sout <= 1'b0;
      link.sout_oe <= 1'b0;
    end else if (edge_count == EDGE_DIRECTION && link.wr_n) begin
      link.sout <= frame_addr[3];
      read_word <= {frame_addr[2:0], 1'b0};
      link.sout_oe <= 1'b1;
    end else if (frame_read && edge_count < EDGE_READ_END) begin
      if (edge_count == EDGE_VALUE_FIRST) begin
        // value snapshot taken here; a register cannot move during a read frame
        link.sout <= addr_value[3];
        read_word <= {addr_value[2:0], 1'b0};
      end else begin
        link.sout <= read_word[3];
        read_word <= {read_word[2:0], 1'b0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // write commit: registers load at the fourth data edge, counters at the eighth;
  // a counter write has no data to wait for, so it commits on the direction edge
  assign write_reg_now = !link.cs_n && !inhibit && !frame_read &&
    edge_count == EDGE_DATA_LAST && frame_addr > ADDR_LAST_COUNTER;
  assign write_cnt_now = !link.cs_n && !inhibit && !link.wr_n &&
    edge_count == EDGE_DIRECTION && frame_addr <= ADDR_LAST_COUNTER;

  // control one and the mode register; both return to defaults on any reset
  always_ff @(posedge sck) begin
    if (reset_all) begin
      control_one <= CONTROL_ONE_RESET;
      initial_mode_select <= INITIAL_MODE_RESET;
    end else if (write_reg_now && frame_addr == ADDR_CONTROL_ONE) begin
      control_one <= {shift_word[2:0], link.sin};
    end else if (write_reg_now && frame_addr == ADDR_INITIAL_MODE) begin
      initial_mode_select <= {shift_word[2:0], link.sin};
    end
  end

  // power-up-clear flag set by power-on only; a host write replaces every bit,
  // so software that wants the flag kept must write it back as one
  always_ff @(posedge sck) begin
    if (srst) begin
      control_register_two <= CONTROL_TWO_RESET;
    end else if (sys_reset) begin
      control_register_two <= control_register_two & ~(4'h_1 << SYSTEM_RESET_BIT);
    end else if (write_reg_now && frame_addr == ADDR_CONTROL_TWO) begin
      control_register_two <= {shift_word[2:0], link.sin};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // time counters: each write frame steps one by one and wraps past all ones
  genvar i;
  generate
    for (i = 0; i <= int'(ADDR_LAST_COUNTER); i++) begin : g_cnt
      always_ff @(posedge sck) begin
        if (reset_all) begin
          counters[i] <= '0;
        end else if (write_cnt_now && frame_addr == 4'(i)) begin
          counters[i] <= counters[i] + 4'h_1;
        end
      end
    end
  endgenerate
endmodule : rtc_device

// [rtc_host.sv]
// rtc_host: controller that drives the serial link from a plain register port.
// assumes: clk 125 MHz; sck made here by a divider, so no second domain here.
`timescale 1ns/1ps
module rtc_host
  import rtc_pkg::*;
(
  input wire logic clk,             // system clock
  input wire logic srst,            // sync reset, active high
  input wire logic [3:0] addr,      // register address
  input wire logic [7:0] wdata,     // write data
  input wire logic wr,              // write strobe
  input wire logic rd,              // read strobe
  output logic [7:0] rdata,         // read data, cycle after rd
  rtc_link_if.host link             // serial pins
);
  typedef enum logic [1:0] {IDLE, SHIFT, DONE} hstate_t;
  hstate_t state;
  logic [3:0] div;
  logic [4:0] nbit;
  logic [15:0] out_word;
  logic [3:0] rx;
  logic [3:0] cmd_addr;
  logic [3:0] wnib;
  logic s1, s2;

  // sout comes from another clock's logic, so two flops first
  always_ff @(posedge clk) begin
    s1 <= link.sout;
    s2 <= s1;
  end

  always_ff @(posedge clk) begin
    if (srst) wnib <= '0;
    else if (wr && addr == REG_WDATA) wnib <= wdata[3:0];
  end

  // frame: addr, filler, then (write) data or (read) 8 edges to listen
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= IDLE;
      link.cs_n <= 1'b1;
      link.sck <= 1'b0;
      link.wr_n <= 1'b1;
      link.sin <= 1'b0;
      div <= '0;
      nbit <= '0;
      out_word <= '0;
      rx <= '0;
      cmd_addr <= '0;
    end else begin
      case (state)
        IDLE: begin
          link.sck <= 1'b0;
          if (wr && addr == REG_CMD && wdata[CMD_GO_BIT]) begin
            cmd_addr <= wdata[3:0];
            link.cs_n <= 1'b0;
            link.wr_n <= wdata[CMD_READ_BIT];
            out_word <= {wdata[3:0], 4'h_0, wnib, 4'h_0};
            nbit <= '0;
            div <= '0;
            state <= SHIFT;
          end else if (wr && addr == REG_CMD && wdata[CMD_SYSRST_BIT]) begin
            cmd_addr <= ADDR_CONTROL_TWO;
            link.cs_n <= 1'b0;
            link.wr_n <= 1'b0;
            out_word <= {ADDR_CONTROL_TWO, 4'h_0, 4'h_1, 4'h_0};
            nbit <= '0;
            div <= '0;
            state <= SHIFT;
          end
        end
        SHIFT: begin
          div <= div + DIV_ONE;
          if (div == 4'(CLK_DIV - 1)) begin
            div <= '0;
            link.sck <= !link.sck;
            if (!link.sck) begin
              nbit <= nbit + 5'h_1;
              // s2 holds the bit the device put out one sck period ago
              if (link.wr_n && nbit >= 5'(WR_EDGE + ADDR_W)) rx <= {rx[2:0], s2};
            end else begin
              link.sin <= out_word[15];
              out_word <= {out_word[14:0], 1'b0};
              if (nbit == 5'(WR_EDGE + ADDR_W + DATA_W)) state <= DONE;
            end
          end
          // first bit goes out before the first rise, so shift it away here too
          if (nbit == 5'h_0 && div == '0 && !link.sck) begin
            link.sin <= out_word[15];
            out_word <= {out_word[14:0], 1'b0};
          end
        end
        DONE: begin
          link.cs_n <= 1'b1;
          link.sck <= 1'b0;
          link.wr_n <= 1'b1;
          state <= IDLE;
        end
        default: state <= IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) rdata <= '0;
    else if (rd && addr == REG_STATUS) rdata <= {rx, 3'b000, state != IDLE};
    else if (rd) rdata <= {cmd_addr, wnib};
    else rdata <= '0;
  end
endmodule : rtc_host

// [rtc_link_properties.sv]
// rtc_link_properties: timing checks on the serial pins between the two ends.
// assumes: clk is the controller clock that also makes sck by its divider.
`timescale 1ns/1ps
module rtc_link_properties (
  input wire logic clk,     // controller clock
  input wire logic srst,    // sync reset, active high
  input wire logic cs_n,    // chip select, active low
  input wire logic wr_n,    // low = write
  input wire logic sck,     // link clock
  input wire logic sin,     // data to device
  input wire logic sout_oe, // device drives sout
  input wire logic backup_n // low = access inhibit
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////////////////////////
  // rising sck edges seen in the current frame, cleared while deselected
  logic [4:0] rises;
  always_ff @(posedge clk) begin
    if (srst || cs_n) begin
      rises <= 5'h_00;
    end else if ($rose(sck)) begin
      rises <= rises + 5'h_01;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // pin relations, sampled on the controller clock
  property p_sck_low_after_cs; $rose(cs_n) |-> ##[0:8] !sck; endproperty
  a_sck_low_after_cs: assert property (p_sck_low_after_cs) else $error("sck high after cs");
  property p_sck_in_frame; $rose(sck) |-> !cs_n; endproperty
  a_sck_in_frame: assert property (p_sck_in_frame) else $error("sck edge outside frame");
  property p_half_period; $rose(sck) |-> sck[*4] ##1 !sck; endproperty
  a_half_period: assert property (p_half_period) else $error("sck half period wrong");
  property p_oe_read_only; $rose(sout_oe) |-> !cs_n && wr_n; endproperty
  a_oe_read_only: assert property (p_oe_read_only) else $error("sout driven outside read");
  property p_no_oe_write; $rose(sck) && !cs_n && !wr_n |=> !sout_oe; endproperty
  a_no_oe_write: assert property (p_no_oe_write) else $error("sout driven in write");
  property p_wr_stable; !cs_n && !$past(cs_n) |-> $stable(wr_n); endproperty
  a_wr_stable: assert property (p_wr_stable) else $error("direction moved in frame");
  property p_sin_stable; $rose(sck) |-> $stable(sin); endproperty
  a_sin_stable: assert property (p_sin_stable) else $error("sin moved at sck rise");
  property p_frame_edges; $rose(cs_n) |-> rises >= 5'h_0c; endproperty
  a_frame_edges: assert property (p_frame_edges) else $error("frame too short");
  property p_inhibit_quiet; !backup_n |-> !$rose(sout_oe); endproperty
  a_inhibit_quiet: assert property (p_inhibit_quiet) else $error("sout driven in backup");
endmodule : rtc_link_properties

// [tb_serial_clock_calendar_access.sv]
// tb_serial_clock_calendar_access: controller and device joined over the link.
// assumes: rtc_pkg, rtc_link_if, both ends and the checker compiled first.
`timescale 1ns/1ps
module tb_serial_clock_calendar_access;
  import rtc_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] addr = 4'h_0;
  logic [7:0] wdata = 8'h_00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic [3:0] control_one;
  logic clock_mode;
  logic dev_sck;
  logic [16:0] seed = 17'h_1_794e;
  int fails = 0;
  int n_tests = 0;
  rtc_link_if lnk ();
  ////////////////////////////////////////////////////////////////////////////////
  // the device needs edges during reset, but the controller holds sck still then
  assign dev_sck = srst ? clk : lnk.sck;
  always #4 clk = ~clk;
  rtc_host u_rtc_host (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .link(lnk.host));
  rtc_device u_rtc_device (.sck(dev_sck), .srst(srst), .link(lnk.device),
    .control_one(control_one), .clock_mode(clock_mode));
  rtc_link_properties u_rtc_link_properties (.clk(clk), .srst(srst), .cs_n(lnk.cs_n),
    .wr_n(lnk.wr_n), .sck(lnk.sck), .sin(lnk.sin), .sout_oe(lnk.sout_oe),
    .backup_n(lnk.backup_n));
  ////////////////////////////////////////////////////////////////////////////////
  // helpers: random source, expectations, bus cycles
  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction : lfsr
  function automatic logic [3:0] next_count(input logic [3:0] v);
    return (v == COUNTER_MAX) ? 4'h_0 : v + 4'h_1;
  endfunction : next_count
  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic bus_wr(input logic [3:0] a, input logic [7:0] w);
    addr <= a;
    wdata <= w;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : bus_wr
  task automatic bus_rd(input logic [3:0] a, output logic [7:0] r);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 r = rdata;
    @(posedge clk);
  endtask : bus_rd
  // one frame: data first, then the command, then poll busy under a bound
  task automatic link_op(input logic [3:0] a, input logic rdn, input logic [3:0] d,
      input logic sys, output logic [3:0] q);
    logic [7:0] c;
    logic [7:0] s;
    int n;
    c = {4'h_0, a};
    c[CMD_READ_BIT] = rdn;
    c[CMD_GO_BIT] = ~sys;
    c[CMD_SYSRST_BIT] = sys;
    bus_wr(REG_WDATA, {4'h_0, d});
    bus_wr(REG_CMD, c);
    repeat (4) @(posedge clk);
    n = 0;
    s = 8'h_01;
    while (s[0] !== 1'b0 && n < 400) begin
      bus_rd(REG_STATUS, s);
      n++;
    end
    if (n == 400) begin
      fails++;
      $display("[FAIL] %0t busy stuck", $time);
    end
    q = s[7:4];
  endtask : link_op
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic [3:0] q;
    logic [3:0] v;
    logic [3:0] d;
    lnk.backup_n = 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    check(control_one, CONTROL_ONE_RESET);
    check({3'h_0, clock_mode}, 4'h_0);
    link_op(ADDR_CONTROL_TWO, 1'b1, 4'h_0, 1'b0, q);
    check(q, CONTROL_TWO_RESET);
    link_op(ADDR_INITIAL_MODE, 1'b0, CLOCK_MODE_VALUE, 1'b0, q);
    check({3'h_0, clock_mode}, 4'h_1);
    link_op(ADDR_INITIAL_MODE, 1'b1, 4'h_0, 1'b0, q);
    check(q, CLOCK_MODE_VALUE);
    link_op(ADDR_CONTROL_ONE, 1'b0, CONTROL_ONE_INIT, 1'b0, q);
    check(control_one, CONTROL_ONE_INIT);
    d = CONTROL_ONE_INIT;
    // random nibbles written then read straight back
    repeat (6) begin
      seed = lfsr(seed);
      d = seed[3:0];
      link_op(ADDR_CONTROL_ONE, 1'b0, d, 1'b0, q);
      check(control_one, d);
      link_op(ADDR_CONTROL_ONE, 1'b1, 4'h_0, 1'b0, q);
      check(q, d);
    end
    // counters step by one whatever data is shifted in
    for (int a = 0; a <= int'(ADDR_LAST_COUNTER); a++) begin
      link_op(4'(a), 1'b1, 4'h_0, 1'b0, v);
      seed = lfsr(seed);
      link_op(4'(a), 1'b0, seed[3:0], 1'b0, q);
      link_op(4'(a), 1'b1, 4'h_0, 1'b0, q);
      check(q, next_count(v));
    end
    // backup low: the write must leave control one alone
    lnk.backup_n <= 1'b0;
    link_op(ADDR_CONTROL_ONE, 1'b0, ~d, 1'b0, q);
    check(control_one, d);
    lnk.backup_n <= 1'b1;
    link_op(ADDR_CONTROL_TWO, 1'b0, 4'(1 << SYSTEM_RESET_BIT), 1'b1, q);
    check(control_one, CONTROL_ONE_RESET);
    check({3'h_0, clock_mode}, 4'h_0);
    conclude();
  end
  // watchdog: about thirty frames of roughly 135 cycles fit well inside
  initial begin
    #400_000;
    fails++;
    conclude();
  end
endmodule : tb_serial_clock_calendar_access
